/* File: hdl/csi2_dphy_rate_init_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_rx_defs.svh"
// Summary of operation
// - the lane-clock range set by software must sit at or above twice the measured sensor clock, within an 80 to 1000 MHz span.
// - the state register shows stop per data lane and clock lane, and whether the clock lane and all enabled data lanes are stopped.
// - the state register shows when a clock is being received on the clock lane.
// - with the range below twice the sensor clock, a start of transmission on an enabled lane flags that lane in bits 0 to 3 of the first error register.
// - the video stage forwards data to the sensor FIFO controller, the deinterlacer and the image converter.
module csi2_dphy_rate_init_sequencer
  import csi_rx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic link_clk,
  input wire logic [`LANES-1:0] lane_idle_stop,
  input wire logic clk_lane_stop,
  output logic phy_power_down_release,
  output logic phy_reset_release,
  output logic controller_reset_release,
  output logic [7:0] phy_test_din,
  output logic phy_test_en,
  output logic phy_test_clr,
  output logic phy_test_clk,
  input wire logic pix_valid,
  input wire logic [`PIX_W-1:0] pix_data,
  output logic sensor_fifo_controller_valid,
  output logic [`PIX_W-1:0] sensor_fifo_controller_data,
  output logic deinterlacer_valid,
  output logic [`PIX_W-1:0] deinterlacer_data,
  output logic image_converter_valid,
  output logic [`PIX_W-1:0] image_converter_data
);
  localparam logic [7:0] WIN_LAST = 8'(`RATE_WINDOW_CYC - 1);

  state_type s;
  state_type next_s;
  logic [`LANES-1:0] sot_err;
  logic lclk_rise;
  logic [`LANES-1:0] lane_on;

  range_lookup_if lk ();

  range_code_lookup u_lookup (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .lk(lk)
  );

  assign lk.rate = s.rate;
  assign lclk_rise = s.lclk_s2 & ~s.lclk_prev;

  // ----------------------------------------------------------------
  // per-lane start of transmission check
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `LANES; i++)
  begin : g_lane
    assign lane_on[i] = (2'(i) <= s.lanes_m1);
    // leaving stop while the range is too low for the sensor clock
    assign sot_err[i] = lane_on[i] & s.stop_prev[i] & ~s.stop_s2[i] &
                        s.clk_active & s.too_low;
  end

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input state_type v);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `OFF_CTRL:
      begin
        w[`CTRL_PWR_BIT] = v.pwr_release;
        w[`CTRL_PHY_RST_BIT] = v.phy_rst_release;
        w[`CTRL_CTL_RST_BIT] = v.ctl_rst_release;
        w[`CTRL_LANES_LSB +: 2] = v.lanes_m1;
        w[`CTRL_ROUTE_LSB +: 3] = v.route;
      end
      `OFF_TEST_DATA:
      begin
        w[7:0] = v.test_data;
        w[`TEST_EN_BIT] = v.test_en;
      end
      `OFF_TEST_CTRL:
      begin
        w[`TEST_CLR_BIT] = v.test_clr;
        w[`TEST_CLK_BIT] = v.test_clk;
      end
      `OFF_RATE: w[`RATE_W-1:0] = v.rate;
      `OFF_RANGE:
      begin
        w[7:0] = lk.code;
        w[`RANGE_OOS_BIT] = lk.out_of_span;
      end
      `OFF_IDS_LOW: w = v.ids_low;
      `OFF_IDS_HIGH: w = v.ids_high;
      `OFF_MASK_FIRST: w[`LANES:0] = v.mask_first;
      `OFF_MASK_SECOND: w = v.mask_second;
      `OFF_ERR_FIRST: w[`LANES:0] = v.err;
      `OFF_PHY_STATE:
      begin
        w[`LANES-1:0] = v.stop_s2[`LANES-1:0];
        w[`STATE_CLK_STOP_BIT] = v.stop_s2[`LANES];
        w[`STATE_CLK_ACT_BIT] = v.clk_active;
        w[`STATE_ALL_STOP_BIT] = v.all_stop;
        w[`STATE_MEAS_LSB +: 8] = v.meas_mhz;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb
  begin
    next_s = s;
    // ----------------------------------------------------------------
    // pin synchronisers; first stage feeds only the second
    // ----------------------------------------------------------------
    next_s.lclk_s1 = link_clk;
    next_s.lclk_s2 = s.lclk_s1;
    next_s.lclk_prev = s.lclk_s2;
    next_s.stop_s1 = {clk_lane_stop, lane_idle_stop};
    next_s.stop_s2 = s.stop_s1;
    next_s.stop_prev = s.stop_s2;
    next_s.all_stop = s.stop_s2[`LANES] &
                      (&(s.stop_s2[`LANES-1:0] | ~lane_on));
    // ----------------------------------------------------------------
    // sensor clock measurement over a 1 us window
    // ----------------------------------------------------------------
    // sampling limits this to clocks below half of ref_clk
    if (s.win_cnt == WIN_LAST)
    begin
      next_s.win_cnt = 8'h00;
      next_s.edge_cnt = 8'h00;
      next_s.meas_mhz = s.edge_cnt + {7'h00, lclk_rise};
      next_s.clk_active = (s.edge_cnt != 8'h00) | lclk_rise;
      next_s.too_low = ({2'h0, s.edge_cnt + {7'h00, lclk_rise}, 1'b0}
                        > s.rate);
    end
    else
    begin
      next_s.win_cnt = s.win_cnt + 8'h01;
      if (s.edge_cnt != 8'hFF)
      begin
        next_s.edge_cnt = s.edge_cnt + {7'h00, lclk_rise};
      end
    end
    // ----------------------------------------------------------------
    // bus data phase: writes
    // ----------------------------------------------------------------
    if (s.a_valid && s.a_write && hready)
    begin
      unique case (s.a_addr)
        `OFF_CTRL:
        begin
          next_s.pwr_release = hwdata[`CTRL_PWR_BIT];
          next_s.phy_rst_release = hwdata[`CTRL_PHY_RST_BIT];
          next_s.ctl_rst_release = hwdata[`CTRL_CTL_RST_BIT];
          next_s.lanes_m1 = hwdata[`CTRL_LANES_LSB +: 2];
          next_s.route = hwdata[`CTRL_ROUTE_LSB +: 3];
        end
        `OFF_TEST_DATA:
        begin
          next_s.test_data = hwdata[7:0];
          next_s.test_en = hwdata[`TEST_EN_BIT];
        end
        `OFF_TEST_CTRL:
        begin
          next_s.test_clr = hwdata[`TEST_CLR_BIT];
          next_s.test_clk = hwdata[`TEST_CLK_BIT];
        end
        `OFF_RATE: next_s.rate = hwdata[`RATE_W-1:0];
        `OFF_IDS_LOW: next_s.ids_low = hwdata;
        `OFF_IDS_HIGH: next_s.ids_high = hwdata;
        `OFF_MASK_FIRST: next_s.mask_first = hwdata[`LANES:0];
        `OFF_MASK_SECOND: next_s.mask_second = hwdata;
        `OFF_ERR_FIRST: next_s.err = s.err & ~hwdata[`LANES:0];
        default: next_s.rate = s.rate;
      endcase
    end
    // a new event beats a write-one-clear in the same cycle
    next_s.err = next_s.err | {next_s.too_low & ~s.too_low, sot_err};
    next_s.irq = |(next_s.err & next_s.mask_first);
    // ----------------------------------------------------------------
    // bus address phase: reads answer with zero wait states
    // ----------------------------------------------------------------
    next_s.a_valid = hsel && htrans[1] && hready;
    next_s.a_write = hwrite;
    next_s.a_addr = haddr[7:0];
    next_s.hreadyout = 1'b1;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      // read sees the result of a write finishing in this cycle
      next_s.hrdata = read_word(haddr[7:0], next_s);
    end
    // ----------------------------------------------------------------
    // video fan-out, held off while the controller is in reset
    // ----------------------------------------------------------------
    next_s.sfc_valid = pix_valid & s.route[0] & s.ctl_rst_release;
    next_s.dei_valid = pix_valid & s.route[1] & s.ctl_rst_release;
    next_s.ic_valid = pix_valid & s.route[2] & s.ctl_rst_release;
    if (pix_valid)
    begin
      next_s.pix_data = pix_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '0;
      s.rate <= `RST_RATE;
      s.lanes_m1 <= `RST_LANES;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign irq = s.irq;
  assign phy_power_down_release = s.pwr_release;
  assign phy_reset_release = s.phy_rst_release;
  assign controller_reset_release = s.ctl_rst_release;
  assign phy_test_din = s.test_data;
  assign phy_test_en = s.test_en;
  assign phy_test_clr = s.test_clr;
  assign phy_test_clk = s.test_clk;
  assign sensor_fifo_controller_valid = s.sfc_valid;
  assign sensor_fifo_controller_data = s.pix_data;
  assign deinterlacer_valid = s.dei_valid;
  assign deinterlacer_data = s.pix_data;
  assign image_converter_valid = s.ic_valid;
  assign image_converter_data = s.pix_data;

  a_range_too_low: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && s.win_cnt == WIN_LAST) |=>
    (s.too_low == ({2'h0, s.meas_mhz, 1'b0} > $past(s.rate))))
    else $error("range check disagrees with measured clock");
  a_all_lanes_stop: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && s.lanes_m1 == 2'h3 && (&s.stop_s2)) |=> s.all_stop)
    else $error("all-stopped flag missing");
  a_clock_seen: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && s.win_cnt == WIN_LAST && s.edge_cnt != 8'h00)
    |=> s.clk_active)
    else $error("clock activity not reported");
  a_sot_flag: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && sot_err != 4'h0) |=>
    ((s.err[`LANES-1:0] & $past(sot_err)) == $past(sot_err)))
    else $error("start of transmission error lost");
  a_deint_fwd: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && pix_valid && s.route[1] && s.ctl_rst_release) |=>
    (deinterlacer_valid && deinterlacer_data == $past(pix_data)))
    else $error("deinterlacer did not get pixel");
  a_irq_level: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && (s.err & s.mask_first) != 5'h00) |-> irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: hdl/csi_rx_defs.svh */
`ifndef CSI_RX_DEFS_SVH
`define CSI_RX_DEFS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_TEST_DATA 8'h04
`define OFF_TEST_CTRL 8'h08
`define OFF_RATE 8'h0C
`define OFF_RANGE 8'h10
`define OFF_IDS_LOW 8'h14
`define OFF_IDS_HIGH 8'h18
`define OFF_MASK_FIRST 8'h1C
`define OFF_MASK_SECOND 8'h20
`define OFF_ERR_FIRST 8'h24
`define OFF_PHY_STATE 8'h28
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_PWR_BIT 0
`define CTRL_PHY_RST_BIT 1
`define CTRL_CTL_RST_BIT 2
`define CTRL_LANES_LSB 4
`define CTRL_ROUTE_LSB 8
`define TEST_EN_BIT 16
`define TEST_CLR_BIT 0
`define TEST_CLK_BIT 1
`define RANGE_OOS_BIT 8
`define STATE_CLK_STOP_BIT 4
`define STATE_CLK_ACT_BIT 5
`define STATE_ALL_STOP_BIT 6
`define STATE_MEAS_LSB 16
`define ERR_RANGE_LOW_BIT 4
// ----------------------------------------------------------------
// widths, reset values, span
// ----------------------------------------------------------------
`define LANES 4
`define RATE_W 11
`define PIX_W 16
`define RST_RATE 11'h050
`define RST_LANES 2'h3
`define SPAN_MIN_MHZ 11'h050
`define SPAN_MAX_MHZ 11'h3E8
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_CLK_MHZ 125
`define RATE_WINDOW_NS 1000
`define RATE_WINDOW_CYC ((`RATE_WINDOW_NS * `REF_CLK_MHZ) / 1000)
`endif

/* File: hdl/csi_rx_pkg.sv */
`include "csi_rx_defs.svh"
package csi_rx_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic out_of_span;
  } lookup_state_type;

  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_prev;
    logic [`LANES:0] stop_s1;
    logic [`LANES:0] stop_s2;
    logic [`LANES:0] stop_prev;
    logic [7:0] win_cnt;
    logic [7:0] edge_cnt;
    logic [7:0] meas_mhz;
    logic clk_active;
    logic too_low;
    logic all_stop;
    logic pwr_release;
    logic phy_rst_release;
    logic ctl_rst_release;
    logic [1:0] lanes_m1;
    logic [2:0] route;
    logic [7:0] test_data;
    logic test_en;
    logic test_clr;
    logic test_clk;
    logic [`RATE_W-1:0] rate;
    logic [31:0] ids_low;
    logic [31:0] ids_high;
    logic [`LANES:0] mask_first;
    logic [31:0] mask_second;
    logic [`LANES:0] err;
    logic irq;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic sfc_valid;
    logic dei_valid;
    logic ic_valid;
    logic [`PIX_W-1:0] pix_data;
  } state_type;
endpackage

/* File: hdl/range_code_lookup.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_rx_defs.svh"
module range_code_lookup
  import csi_rx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  range_lookup_if.responder lk
);
  // ----------------------------------------------------------------
  // band lower edges (MHz, ascending) and codes for a 27 MHz reference
  // ----------------------------------------------------------------
  localparam int BANDS = 29;
  localparam logic [`RATE_W-1:0] BAND_EDGE [0:BANDS-1] = '{
    11'h050, 11'h05A, 11'h064, 11'h06E, 11'h07D, 11'h08C, 11'h096,
    11'h0A0, 11'h0B4, 11'h0C8, 11'h0D2, 11'h0F0, 11'h0FA, 11'h10E,
    11'h12C, 11'h14A, 11'h168, 11'h190, 11'h1C2, 11'h1F4, 11'h226,
    11'h258, 11'h28A, 11'h2BC, 11'h2EE, 11'h320, 11'h352, 11'h384,
    11'h3B6};
  localparam logic [7:0] BAND_CODE [0:BANDS-1] = '{
    8'h00, 8'h20, 8'h40, 8'h02, 8'h22, 8'h42, 8'h04, 8'h04, 8'h44,
    8'h06, 8'h26, 8'h46, 8'h08, 8'h28, 8'h08, 8'h2A, 8'h4A, 8'h2C,
    8'h4C, 8'h20, 8'h2E, 8'h10, 8'h30, 8'h12, 8'h32, 8'h14, 8'h34,
    8'h54, 8'h74};

  lookup_state_type s;
  lookup_state_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.code = BAND_CODE[0];
    // ascending scan: a rate on a shared edge lands in the higher band
    for (int i = 0; i < BANDS; i++)
    begin
      if (lk.rate >= BAND_EDGE[i])
      begin
        next_s.code = BAND_CODE[i];
      end
    end
    next_s.out_of_span = (lk.rate < `SPAN_MIN_MHZ) ||
                         (lk.rate > `SPAN_MAX_MHZ);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign lk.code = s.code;
  assign lk.out_of_span = s.out_of_span;

  a_edge_high_band: assert property (
    @(posedge ref_clk) disable iff (reset)
    (clk_en && lk.rate == 11'h320) |=> (lk.code == 8'h14))
    else $error("rate on 800 edge did not pick upper band");
  a_span_flag: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en |=> (lk.out_of_span ==
      ($past(lk.rate) < 11'h050 || $past(lk.rate) > 11'h3E8)))
    else $error("span flag wrong for rate");
endmodule
`default_nettype wire

/* File: hdl/range_lookup_if.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_rx_defs.svh"
interface range_lookup_if;
  logic [`RATE_W-1:0] rate;
  logic [7:0] code;
  logic out_of_span;
  modport requester (output rate, input code, input out_of_span);
  modport responder (input rate, output code, output out_of_span);
endinterface
`default_nettype wire

/* File: verification/sensor_lane_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// camera side: forwarded clock and lane stop levels
// ----------------------------------------------------------------
module sensor_lane_model
(
  input wire logic run,
  input wire logic [3:0] sot_lanes,
  output logic link_clk,
  output logic [3:0] lane_idle_stop,
  output logic clk_lane_stop
);
  // odd start offset keeps the phase unrelated to the host clock
  initial
  begin
    link_clk = 1'b0;
    #37;
    forever
    begin
      #80;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  // lanes rest in stop until a burst begins on them
  assign lane_idle_stop = ~sot_lanes;
  assign clk_lane_stop = ~run;
endmodule
`default_nettype wire

/* File: verification/test_csi2_dphy_rate_init_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "csi_rx_defs.svh"
module test_csi2_dphy_rate_init_sequencer import csi_rx_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic pix_valid = 1'b0;
  logic [15:0] pix_data = 16'h0000;
  logic run = 1'b0;
  logic [3:0] sot_lanes = 4'h0;
  logic hready, hreadyout, hresp, irq, link_clk, clk_lane_stop;
  logic [31:0] hrdata;
  logic [3:0] lane_idle_stop;
  logic pwr, prst, crst, t_en, t_clr, t_clk, sfc_v, dei_v, ic_v;
  logic [7:0] t_din, din;
  logic [15:0] sfc_d, dei_d, ic_d;
  logic en, clr, tck;
  logic [31:0] d;
  logic [7:0] ta[12];
  logic [31:0] td[12];
  logic [10:0] rt[11];
  logic [8:0] cd[11];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  always #4 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  csi2_dphy_rate_init_sequencer i_dut
  (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .link_clk(link_clk),
    .lane_idle_stop(lane_idle_stop), .clk_lane_stop(clk_lane_stop),
    .phy_power_down_release(pwr), .phy_reset_release(prst),
    .controller_reset_release(crst), .phy_test_din(t_din),
    .phy_test_en(t_en), .phy_test_clr(t_clr), .phy_test_clk(t_clk),
    .pix_valid(pix_valid), .pix_data(pix_data),
    .sensor_fifo_controller_valid(sfc_v),
    .sensor_fifo_controller_data(sfc_d), .deinterlacer_valid(dei_v),
    .deinterlacer_data(dei_d), .image_converter_valid(ic_v),
    .image_converter_data(ic_d)
  );
  sensor_lane_model i_sensor
  (
    .run(run), .sot_lanes(sot_lanes), .link_clk(link_clk),
    .lane_idle_stop(lane_idle_stop), .clk_lane_stop(clk_lane_stop)
  );
  // ----------------------------------------------------------------
  // checks and bus access
  // ----------------------------------------------------------------
  task check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // the master never assumes wait states, it waits on hready
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
           output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hready !== 1'b1);
    r = hrdata;
    check1(n < 40, 1'b1);
    check1(hresp, 1'b0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb(a, 1'b1, wd, x);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m,
           input logic [31:0] e);
    logic [31:0] x;
    ahb(a, 1'b0, 32'h0000_0000, x);
    check32(x & m, e);
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    ta = '{`OFF_TEST_CTRL, `OFF_TEST_CTRL, `OFF_TEST_DATA, `OFF_TEST_CTRL,
           `OFF_TEST_CTRL, `OFF_TEST_DATA, `OFF_TEST_DATA, `OFF_TEST_CTRL,
           `OFF_TEST_DATA, `OFF_TEST_DATA, `OFF_TEST_CTRL, `OFF_TEST_CTRL};
    td = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h2, 32'h44, 32'h1_0044, 32'h0,
           32'h44, 32'h2E, 32'h2, 32'h0};
    // band edges go up, outside the span the flag is set
    rt = '{11'h3CF, 11'h3E8, 11'h320, 11'h339, 11'h11D, 11'h050,
           11'h05A, 11'h1DB, 11'h04F, 11'h3E9, 11'h000};
    cd = '{9'h074, 9'h074, 9'h014, 9'h014, 9'h028, 9'h000, 9'h020,
           9'h04C, 9'h100, 9'h174, 9'h02E};
    rt[10] = 11'((74 * 16) / 2 / 2 * 2);
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check32({29'h0, crst, prst, pwr}, 32'h0000_0000);
    check1(irq, 1'b0);
    rdc(`OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0030);
    rdc(`OFF_RATE, 32'hFFFF_FFFF, 32'h0000_0050);
    rdc(`OFF_RANGE, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`OFF_PHY_STATE, 32'h0000_007F, 32'h0000_005F);
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    {en, din, clr, tck} = 11'h000;
    for (i = 0; i < 12; i++)
    begin
      wr(ta[i], td[i]);
      if (ta[i] == `OFF_TEST_DATA)
        {en, din} = {td[i][16], td[i][7:0]};
      else
        {tck, clr} = td[i][1:0];
      #1;
      check32({21'h0, t_en, t_din, t_clr, t_clk},
              {21'h0, en, din, clr, tck});
    end
    $display("test phy program done");
    for (i = 0; i < 4; i++)
    begin
      d = (32'h1 << i) - 32'h1;
      wr(`OFF_CTRL, d);
      #1;
      check32({29'h0, crst, prst, pwr}, {29'h0, d[2:0]});
    end
    $display("test release done");
    for (i = 0; i < 3; i++)
    begin
      wr(`OFF_CTRL, 32'h0000_0007 | (32'h0000_0100 << i));
      @(posedge ref_clk);
      pix_valid <= 1'b1;
      pix_data <= 16'h1234 + 16'(i);
      @(posedge ref_clk);
      pix_valid <= 1'b0;
      #1;
      check32({29'h0, ic_v, dei_v, sfc_v}, 32'h1 << i);
      d = {16'h0, (i == 0) ? sfc_d : (i == 1) ? dei_d : ic_d};
      check32(d, 32'h0000_1234 + i);
    end
    $display("test stream done");
    // clock enable low must hold every register, outputs included
    @(posedge ref_clk);
    clk_en <= 1'b0;
    pix_valid <= 1'b1;
    pix_data <= 16'hBEEF;
    repeat (3) @(posedge ref_clk);
    #1;
    check32({15'h0, ic_v, ic_d}, 32'h0000_1236);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    pix_valid <= 1'b0;
    $display("test freeze done");
    wr(`OFF_IDS_LOW, 32'h0123_4567);
    wr(`OFF_IDS_HIGH, 32'h89AB_CDEF);
    wr(`OFF_MASK_SECOND, 32'hA5A5_5A5A);
    wr(`OFF_MASK_FIRST, 32'hFFFF_FFFF);
    rdc(`OFF_IDS_LOW, 32'hFFFF_FFFF, 32'h0123_4567);
    rdc(`OFF_IDS_HIGH, 32'hFFFF_FFFF, 32'h89AB_CDEF);
    rdc(`OFF_MASK_SECOND, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
    rdc(`OFF_MASK_FIRST, 32'hFFFF_FFFF, 32'h0000_001F);
    $display("test storage done");
    for (i = 0; i < 11; i++)
    begin
      wr(`OFF_RATE, {21'h0, rt[i]});
      repeat (2) @(posedge ref_clk);
      rdc(`OFF_RANGE, 32'h0000_01FF, {23'h0, cd[i]});
    end
    $display("test range done");
    @(posedge ref_clk);
    run <= 1'b1;
    repeat (300) @(posedge ref_clk);
    rdc(`OFF_PHY_STATE, 32'h0000_003F, 32'h0000_002F);
    // one lane enabled, so the burst on lane 2 must not flag
    wr(`OFF_RATE, 32'h0000_0004);
    repeat (300) @(posedge ref_clk);
    sot_lanes <= 4'b0101;
    repeat (10) @(posedge ref_clk);
    sot_lanes <= 4'h0;
    repeat (5) @(posedge ref_clk);
    rdc(`OFF_ERR_FIRST, 32'hFFFF_FFFF, 32'h0000_0011);
    check1(irq, 1'b1);
    wr(`OFF_MASK_FIRST, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check1(irq, 1'b0);
    wr(`OFF_MASK_FIRST, 32'h0000_001F);
    repeat (2) @(posedge ref_clk);
    check1(irq, 1'b1);
    wr(`OFF_ERR_FIRST, 32'h0000_0011);
    rdc(`OFF_ERR_FIRST, 32'hFFFF_FFFF, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check1(irq, 1'b0);
    $display("test link done");
    give_verdict();
  end
endmodule
`default_nettype wire
